// ===== verilog/ttd_params.svh
// Constants of the transient threshold and debounce stage
`ifndef TTD_PARAMS_SVH
`define TTD_PARAMS_SVH

// ==========================================================================
// Register map
`define TTD_ADDR_THS        8'h1F
`define TTD_ADDR_COUNT      8'h20
`define TTD_THS_RESET       8'h00
`define TTD_COUNT_RESET     8'h00
`define TTD_THS_MODE_BIT    7
`define TTD_THS_MSB         6
`define TTD_RDATA_IDLE      8'h00

// ==========================================================================
// Per-axis threshold split fields (one bit high, six bits low)
`define TTD_SPLIT_HI_BIT    0
`define TTD_SPLIT_LO_MSB    7
`define TTD_SPLIT_LO_LSB    2

// ==========================================================================
// Full-scale codes and threshold scaling
`define TTD_FS_2G           2'h0
`define TTD_FS_4G           2'h1
`define TTD_FS_8G           2'h2
`define TTD_SHIFT_8G        4'h6
`define TTD_SHIFT_4G        4'h7
`define TTD_SHIFT_2G        4'h8

// ==========================================================================
// Timing: one step unit is 1.25 ms, clock period 5 ns
`define TTD_STEP_UNIT_NS    1250000
`define TTD_CLK_PERIOD_NS   5

// ODR period in 1.25 ms units, codes 0 (800 Hz) to 7 (1.56 Hz)
`define TTD_ODR_MULT_0      10'h001
`define TTD_ODR_MULT_1      10'h002
`define TTD_ODR_MULT_2      10'h004
`define TTD_ODR_MULT_3      10'h008
`define TTD_ODR_MULT_4      10'h010
`define TTD_ODR_MULT_5      10'h040
`define TTD_ODR_MULT_6      10'h080
`define TTD_ODR_MULT_7      10'h200

// Longest debounce step per power mode, in 1.25 ms units
`define TTD_CAP_NORMAL      10'h010
`define TTD_CAP_LOW_NOISE_LOW_POWER_MODE        10'h040
`define TTD_CAP_HIRES       10'h002
`define TTD_CAP_LOWPWR      10'h080

`endif

// ===== verilog/ttd_pkg.sv
// Types shared by the transient threshold and debounce stage
package ttd_pkg;

  // ========================================================================
  // Oversampling power modes
  typedef enum logic [1:0] {
    TTD_MODE_NORMAL = 2'b00,
    TTD_MODE_LOW_NOISE_LOW_POWER_MODE   = 2'b01,
    TTD_MODE_HIRES  = 2'b10,
    TTD_MODE_LOWPWR = 2'b11
  } ttd_power_mode_t;

  // ========================================================================
  // Debounce counter behaviour on a failed period
  typedef enum logic {
    TTD_DB_DECREMENT = 1'b0,
    TTD_DB_CLEAR     = 1'b1
  } ttd_db_mode_t;

endpackage

// ===== verilog/ttd_axis_compare.sv
// One axis of the transient threshold comparison
`timescale 1ns/10ps
`include "ttd_params.svh"

module ttd_axis_compare
  import ttd_pkg::*;
(
  input  wire logic        [13:0] sample,
  input  wire logic        [6:0]  threshold,
  input  wire logic        [3:0]  scale_shift,
  input  wire logic               axis_enable,
  output logic                    exceeds
);

  logic [14:0] magnitude;
  logic [14:0] limit;

  // ========================================================================
  // Magnitude against threshold at 63 mg per count
  // Magnitude covers both polarities; -8192 stays representable at 15 bits
  always_comb begin
    if (sample[13]) begin
      magnitude = 15'(~{sample[13], sample} + 15'h0001);
    end else begin
      magnitude = {1'b0, sample};
    end
    limit   = 15'({8'h00, threshold} << scale_shift);
    exceeds = axis_enable && (magnitude > limit); // [R13]
  end

endmodule

// ===== verilog/ttd_transient_debounce.sv
// Transient threshold and debounce stage of the accelerometer
// What this block does
// [R1] A set per-axis select bit gives each axis its own threshold.
// [R2] In per-axis use, X takes the low seven bits of the threshold register.
// [R3] In per-axis use, Y takes one high bit plus six bits of the next byte.
// [R4] In per-axis use, Z takes one high bit plus six bits of the next byte.
// [R5] With mode bit zero a failed period decrements the debounce counter.
// [R6] With mode bit one a failed period clears the debounce counter.
// [R7] The threshold is unsigned 7-bit at 63 mg per count, 8 g scale.
// [R8] Low-noise mode limits the measurement range to 4 g.
// [R9] The flag rises once the counter reaches the programmed count.
// [R10] The counter steps once per data-rate period.
// [R11] At low data rates the step is capped per power mode.
// [R12] Hybrid operation doubles every step.
// [R13] An enabled axis meets the condition when above threshold.
// [R14] Filtered data is compared unless the bypass bit is set.
// [R15] A holding period adds one, saturating at the programmed count.
`timescale 1ns/10ps
`include "ttd_params.svh"

module ttd_transient_debounce
  import ttd_pkg::*;
#(
  parameter int unsigned STEP_UNIT_CYCLES =
    `TTD_STEP_UNIT_NS / `TTD_CLK_PERIOD_NS
)
(
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // Register port from the serial interface
  input  wire logic        [7:0]       reg_addr,
  input  wire logic        [7:0]       reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic             [7:0]       reg_rdata,
  // Configuration held elsewhere in the device
  input  wire logic                    per_axis_ths_en,
  input  wire logic        [7:0]       y_ths_hi_reg,
  input  wire logic        [7:0]       y_ths_lo_reg,
  input  wire logic        [7:0]       z_ths_hi_reg,
  input  wire logic        [7:0]       z_ths_lo_reg,
  input  wire logic        [2:0]       axis_enable,
  input  wire logic                    hpf_bypass,
  input  wire logic        [1:0]       full_scale_select,
  input  wire logic                    low_noise_en,
  input  wire ttd_power_mode_t         low_noise_low_power_mode,
  input  wire logic        [2:0]       odr_select,
  input  wire logic                    hybrid_en,
  // Sample stream, one strobe per output data period
  input  wire logic                    sample_valid,
  input  wire logic        [13:0]      raw_x,
  input  wire logic        [13:0]      raw_y,
  input  wire logic        [13:0]      raw_z,
  input  wire logic        [13:0]      hpf_x,
  input  wire logic        [13:0]      hpf_y,
  input  wire logic        [13:0]      hpf_z,
  // Results
  output logic                         event_flag,
  output logic             [2:0]       axis_flags,
  output logic             [7:0]       debounce_count
);

  // ========================================================================
  // Registers 0x1F and 0x20
  logic [7:0] ths_q, ths_d;
  logic [7:0] target_q, target_d;
  logic [7:0] rdata_q, rdata_d;

  always_comb begin
    ths_d    = ths_q;
    target_d = target_q;
    rdata_d  = `TTD_RDATA_IDLE;
    if (reg_wr && reg_addr == `TTD_ADDR_THS) begin
      ths_d = reg_wdata;
    end
    if (reg_wr && reg_addr == `TTD_ADDR_COUNT) begin
      target_d = reg_wdata;
    end
    // Unmapped reads return zero
    if (reg_rd) begin
      case (reg_addr)
        `TTD_ADDR_THS:   rdata_d = ths_q;
        `TTD_ADDR_COUNT: rdata_d = target_q;
        default:         rdata_d = `TTD_RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ths_q    <= `TTD_THS_RESET;
      target_q <= `TTD_COUNT_RESET;
      rdata_q  <= `TTD_RDATA_IDLE;
    end else begin
      ths_q    <= ths_d;
      target_q <= target_d;
      rdata_q  <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ========================================================================
  // Threshold selection and scaling
  logic [6:0]  ths_x, ths_y, ths_z;
  logic [1:0]  fs_eff;
  logic [3:0]  shift;
  logic [13:0] in_x, in_y, in_z;
  logic [2:0]  exceed;

  always_comb begin
    ths_x = ths_q[`TTD_THS_MSB:0]; // [R2]
    ths_y = ths_q[`TTD_THS_MSB:0];
    ths_z = ths_q[`TTD_THS_MSB:0];
    if (per_axis_ths_en) begin // [R1]
      ths_y = {y_ths_hi_reg[`TTD_SPLIT_HI_BIT],
               y_ths_lo_reg[`TTD_SPLIT_LO_MSB:`TTD_SPLIT_LO_LSB]}; // [R3]
      ths_z = {z_ths_hi_reg[`TTD_SPLIT_HI_BIT],
               z_ths_lo_reg[`TTD_SPLIT_LO_MSB:`TTD_SPLIT_LO_LSB]}; // [R4]
    end
    // Low-noise caps the range at 4 g whatever the range select says
    // The spare code counts as 8 g, so it is capped as well
    fs_eff = full_scale_select;
    if (low_noise_en && full_scale_select >= `TTD_FS_8G) begin
      fs_eff = `TTD_FS_4G; // [R8]
    end
    // Data counts are finer at smaller ranges, so the limit shifts more
    case (fs_eff)
      `TTD_FS_2G: shift = `TTD_SHIFT_2G; // [R7]
      `TTD_FS_4G: shift = `TTD_SHIFT_4G;
      default:    shift = `TTD_SHIFT_8G;
    endcase
    in_x = hpf_bypass ? raw_x : hpf_x; // [R14]
    in_y = hpf_bypass ? raw_y : hpf_y;
    in_z = hpf_bypass ? raw_z : hpf_z;
  end

  ttd_axis_compare u_cmp_x (
    .sample      (in_x),
    .threshold   (ths_x),
    .scale_shift (shift),
    .axis_enable (axis_enable[0]),
    .exceeds     (exceed[0])
  );

  ttd_axis_compare u_cmp_y (
    .sample      (in_y),
    .threshold   (ths_y),
    .scale_shift (shift),
    .axis_enable (axis_enable[1]),
    .exceeds     (exceed[1])
  );

  ttd_axis_compare u_cmp_z (
    .sample      (in_z),
    .threshold   (ths_z),
    .scale_shift (shift),
    .axis_enable (axis_enable[2]),
    .exceeds     (exceed[2])
  );

  // ========================================================================
  // Debounce step length in 1.25 ms units
  logic [9:0] odr_mult, cap_mult, step_mult;

  always_comb begin
    case (odr_select)
      3'h0:    odr_mult = `TTD_ODR_MULT_0;
      3'h1:    odr_mult = `TTD_ODR_MULT_1;
      3'h2:    odr_mult = `TTD_ODR_MULT_2;
      3'h3:    odr_mult = `TTD_ODR_MULT_3;
      3'h4:    odr_mult = `TTD_ODR_MULT_4;
      3'h5:    odr_mult = `TTD_ODR_MULT_5;
      3'h6:    odr_mult = `TTD_ODR_MULT_6;
      default: odr_mult = `TTD_ODR_MULT_7;
    endcase
    case (low_noise_low_power_mode)
      TTD_MODE_NORMAL: cap_mult = `TTD_CAP_NORMAL; // [R11]
      TTD_MODE_LOW_NOISE_LOW_POWER_MODE:   cap_mult = `TTD_CAP_LOW_NOISE_LOW_POWER_MODE;
      TTD_MODE_HIRES:  cap_mult = `TTD_CAP_HIRES;
      TTD_MODE_LOWPWR: cap_mult = `TTD_CAP_LOWPWR;
      default:         cap_mult = `TTD_CAP_NORMAL;
    endcase
    step_mult = (odr_mult < cap_mult) ? odr_mult : cap_mult; // [R10]
    // Hybrid halves the effective rate; widths hold 2 x 128 units
    if (hybrid_en) begin
      step_mult = 10'(step_mult << 1); // [R12]
    end
  end

  // ========================================================================
  // Step timer: a unit prescaler then a unit counter
  // Free-running; a rate change takes effect at the next unit boundary
  logic [31:0] pre_q, pre_d;
  logic [9:0]  unit_q, unit_d;
  logic        unit_tick, step_tick;

  always_comb begin
    unit_tick = (pre_q == 32'(STEP_UNIT_CYCLES - 1));
    pre_d     = unit_tick ? 32'h0000_0000 : pre_q + 32'h0000_0001;
    step_tick = unit_tick && (unit_q >= step_mult - 10'h001);
    unit_d    = unit_q;
    if (unit_tick) begin
      unit_d = step_tick ? 10'h000 : unit_q + 10'h001;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_q  <= 32'h0000_0000;
      unit_q <= 10'h000;
    end else begin
      pre_q  <= pre_d;
      unit_q <= unit_d;
    end
  end

  // ========================================================================
  // Condition capture and debounce counter
  // Condition of the latest sample stands for the whole step period
  logic [2:0] cond_q, cond_d;
  logic [7:0] cnt_q, cnt_d;
  logic       flag_q, flag_d;
  logic [2:0] axf_q, axf_d;

  always_comb begin
    cond_d = sample_valid ? exceed : cond_q;
    cnt_d  = cnt_q;
    flag_d = flag_q;
    axf_d  = axf_q;
    if (step_tick) begin
      if (|cond_q) begin
        if (cnt_q < target_q) begin
          cnt_d = cnt_q + 8'h01; // [R15]
        end
        // Saturated count means the debounce time has elapsed
        flag_d = (cnt_d == target_q); // [R9]
        axf_d  = flag_d ? cond_q : 3'h0;
      end else begin
        if (ths_q[`TTD_THS_MODE_BIT] == TTD_DB_CLEAR) begin
          cnt_d = 8'h00; // [R6]
        end else if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01; // [R5]
        end
        flag_d = 1'b0;
        axf_d  = 3'h0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cond_q <= 3'h0;
      cnt_q  <= 8'h00;
      flag_q <= 1'b0;
      axf_q  <= 3'h0;
    end else begin
      cond_q <= cond_d;
      cnt_q  <= cnt_d;
      flag_q <= flag_d;
      axf_q  <= axf_d;
    end
  end

  assign event_flag     = flag_q;
  assign axis_flags     = axf_q;
  assign debounce_count = cnt_q;

endmodule

// ===== bench/ttd_monitor.sv
// Port checker for the transient threshold and debounce stage
`timescale 1ns/10ps
module ttd_monitor #(
  parameter int unsigned STEP_UNIT_CYCLES = 4
) (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       event_flag,
  input wire logic [2:0] axis_flags,
  input wire logic [7:0] debounce_count
);
  logic [7:0]  tgt_q, tgt_d, cnt_q;
  logic        mode_q, mode_d;
  logic [15:0] gap_q, gap_d;
  // =======================================================================
  // Shadow of target and mode; cycles since the counter last moved
  always_comb begin
    tgt_d = (reg_wr && reg_addr == 8'h20) ? reg_wdata : tgt_q;
    mode_d = (reg_wr && reg_addr == 8'h1F) ? reg_wdata[7] : mode_q;
    gap_d = (debounce_count != cnt_q) ? 16'h0000 : gap_q + 16'h0001;
  end
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tgt_q <= 8'h00;
      mode_q <= 1'b0;
      gap_q <= 16'h0000;
      cnt_q <= 8'h00;
    end else begin
      tgt_q <= tgt_d;
      mode_q <= mode_d;
      gap_q <= gap_d;
      cnt_q <= debounce_count;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  AST_RD_IDLE: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  AST_RD_UNMAP: assert property (
    reg_rd && reg_addr != 8'h1F && reg_addr != 8'h20
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_RD_TGT: assert property (
    reg_rd && !reg_wr && reg_addr == 8'h20 |=> reg_rdata == tgt_q)
    else $error("count readback wrong");
  AST_CNT_UP: assert property (
    $changed(debounce_count) && debounce_count > $past(debounce_count)
    |-> debounce_count == $past(debounce_count) + 8'h01)
    else $error("counter jumped up");
  // Mode as it stood at the step edge, not just after it
  AST_CNT_DOWN: assert property (
    debounce_count < $past(debounce_count) |-> debounce_count ==
    ($past(mode_q) ? 8'h00 : $past(debounce_count) - 8'h01))
    else $error("counter fell wrongly");
  AST_CNT_CAP: assert property (
    debounce_count <= tgt_q) else $error("counter above target");
  AST_FLAG_RISE: assert property (
    $rose(event_flag) |-> debounce_count == $past(tgt_q))
    else $error("flag rose early");
  AST_FLAG_AXES: assert property (
    event_flag |-> axis_flags != 3'h0) else $error("flag without axis");
  AST_STEP_GAP: assert property (
    $changed(debounce_count) |-> gap_q >= STEP_UNIT_CYCLES - 2)
    else $error("step too short");
  COV_FLAG: cover property ($rose(event_flag));
  COV_CLEAR: cover property (mode_q && $fell(debounce_count != 8'h00));
  COV_READ: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind ttd_transient_debounce ttd_monitor #(
  .STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)
) u_mon (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .event_flag(event_flag),
  .axis_flags(axis_flags), .debounce_count(debounce_count));

// ===== bench/ttd_host_model.sv
// Host side of the register port: single byte writes and reads
`timescale 1ns/10ps
module ttd_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
  end
  // Strobe held over one edge; data arrives the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge core_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

// ===== bench/tb_transient_threshold_debounce.sv
// Self-checking testbench of the transient threshold and debounce stage
`timescale 1ns/10ps
module tb_transient_threshold_debounce;
  import ttd_pkg::*;
  localparam int unsigned SU = 4;
  logic            core_clk = 1'b0, resetn = 1'b0;
  logic [7:0]      reg_addr, reg_wdata, reg_rdata, dbc, yh, yl, zh, zl;
  logic            reg_wr, reg_rd, per_axis, bypass, lnoise, hybrid;
  logic            svalid, flag;
  logic [2:0]      ena, odr, axf;
  logic [1:0]      fs;
  logic [6:0]      ths;
  ttd_power_mode_t pmode;
  logic [13:0]     rx, ry, rz, hx, hy, hz;
  logic [31:0]     lfsr = 32'hEFFA5CA5;
  int              num_errors = 0, n_compared = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  ttd_host_model host (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  ttd_transient_debounce #(.STEP_UNIT_CYCLES(SU)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .per_axis_ths_en(per_axis),
    .y_ths_hi_reg(yh), .y_ths_lo_reg(yl), .z_ths_hi_reg(zh),
    .z_ths_lo_reg(zl), .axis_enable(ena), .hpf_bypass(bypass),
    .full_scale_select(fs), .low_noise_en(lnoise),
    .low_noise_low_power_mode(pmode), .odr_select(odr),
    .hybrid_en(hybrid), .sample_valid(svalid), .raw_x(rx), .raw_y(ry),
    .raw_z(rz), .hpf_x(hx), .hpf_y(hy), .hpf_z(hz), .event_flag(flag),
    .axis_flags(axf), .debounce_count(dbc));
  // =======================================================================
  // Expectations and helpers
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic int exp_step(input logic [2:0] o, input logic [1:0] m,
                                  input logic h);
    int p, c;
    p = (o == 3'h7) ? 512 : (o >= 3'h5) ? (16 << (o - 3'h3)) : (1 << o);
    c = (m == 2'h0) ? 16 : (m == 2'h1) ? 64 : (m == 2'h2) ? 2 : 128;
    return (p < c ? p : c) * SU * (h ? 2 : 1);
  endfunction
  function automatic logic [2:0] exp_axes();
    logic [13:0] s[3];
    logic [6:0]  t[3];
    int          sh, a;
    s[0] = bypass ? rx : hx;
    s[1] = bypass ? ry : hy;
    s[2] = bypass ? rz : hz;
    t[0] = ths;
    t[1] = per_axis ? {yh[0], yl[7:2]} : ths;
    t[2] = per_axis ? {zh[0], zl[7:2]} : ths;
    // 2 g range keeps its own scale; low noise caps 8 g at 4 g
    sh = (fs == 2'h0) ? 8 : (fs == 2'h1 || lnoise) ? 7 : 6;
    for (int i = 0; i < 3; i++) begin
      a = $signed(s[i]);
      a = (a < 0) ? -a : a;
      exp_axes[i] = ena[i] && (a > (int'(t[i]) << sh));
    end
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for the next counter move, in cycles
  task automatic wait_chg(output int n);
    logic [7:0] v;
    v = dbc;
    n = 0;
    while (dbc === v && n < 5000) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 5000) check(16'h0000, 16'h0001);
  endtask
  // One random configuration; target 1 with clear mode settles in a step
  task automatic rnd_case();
    logic [2:0] e;
    lfsr = nxt(lfsr);
    {per_axis, bypass, lnoise, hybrid, fs, ena, ths} = lfsr[15:0];
    lfsr = nxt(lfsr);
    {rx, ry} = lfsr[27:0];
    lfsr = nxt(lfsr);
    {rz, hx} = lfsr[27:0];
    lfsr = nxt(lfsr);
    {hy, hz} = lfsr[27:0];
    lfsr = nxt(lfsr);
    {yh, yl, zh, zl} = lfsr;
    host.wr(8'h1F, {1'b1, ths});
    repeat (3 * exp_step(odr, pmode, hybrid) + 4) @(posedge core_clk);
    #1 e = exp_axes();
    check(16'(flag), 16'(|e));
    if (|e) check(16'(axf), 16'(e));
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 50000) begin
      num_errors++;
      wrap_up();
    end
  end
  // =======================================================================
  // Main sequence
  initial begin
    int         n;
    logic [7:0] rv;
    {per_axis, lnoise, hybrid, svalid, odr, ths} = 14'h0001;
    {bypass, fs, ena} = {1'b1, 2'h2, 3'h1};
    pmode = TTD_MODE_NORMAL;
    {rx, ry, rz, hx, hy, hz, yh, yl, zh, zl} = '0;
    repeat (5) @(posedge core_clk);
    #1 {resetn, svalid} = 2'h3;
    host.rd(8'h1F, rv);
    check(16'(rv), 16'h0000);
    host.wr(8'h21, 8'hA5);
    host.rd(8'h21, rv);
    check(16'(rv), 16'h0000);
    host.wr(8'h20, 8'h01);
    host.rd(8'h20, rv);
    check(16'(rv), 16'h0001);
    repeat (40) rnd_case();
    // Step length for every data rate and power mode
    // X only, raw data, 8 g: a full-scale X sample holds every step
    {ena, bypass, per_axis, fs, lnoise, rx} =
      {3'h1, 2'h2, 2'h2, 1'b0, 14'h1FFF};
    host.wr(8'h1F, 8'h01);
    host.wr(8'h20, 8'hFF);
    for (int o = 0; o < 8; o++) begin
      for (int m = 0; m < 4; m++) begin
        {odr, hybrid} = {o[2:0], o[0] ^ m[0]};
        pmode = ttd_power_mode_t'(m[1:0]);
        wait_chg(n);
        wait_chg(n);
        check(16'(n), 16'(exp_step(odr, pmode, hybrid)));
      end
    end
    // Failed period after reaching the target, in both counter modes
    resetn = 1'b0;
    @(posedge core_clk);
    #1 {resetn, odr, hybrid} = 5'h10;
    pmode = TTD_MODE_NORMAL;
    for (int md = 0; md < 2; md++) begin
      rx = 14'h1FFF;
      host.wr(8'h1F, {md[0], 7'h01});
      host.wr(8'h20, 8'h03);
      for (int i = 0; i < 60 && dbc !== 8'h03; i++) begin
        @(posedge core_clk);
        #1 n = i;
      end
      check(16'(flag), 16'h0001);
      rx = 14'h0000;
      wait_chg(n);
      check(16'(dbc), md ? 16'h0000 : 16'h0002);
      check(16'(flag), 16'h0000);
    end
    wrap_up();
  end
endmodule
